// File: bench/gpsc_chk.sv
// checker: port relations of the configuration block
// assumes a bind onto gpsc_top
`default_nettype none
module gpsc_chk (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire gpsc_pkg::gpsc_req_t req_i,
    input wire logic [7:0] rdata_o,
    input wire logic ring_indicator_one_n_i,
    input wire logic ring_indicator_two_n_i,
    input wire logic suspend_o,
    input wire logic alt_id_en_o,
    input wire logic [3:0] flash_seg_en_o,
    input wire logic flash_wr_en_o,
    input wire logic [7:0] logical_device_select_o,
    input wire logic [7:0] gpio_sel_one_o,
    input wire logic [7:0] gpio_sel_two_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_wr(a);
        req_i.wr && req_i.addr == a;
    endsequence
    sequence s_calm;
        $stable({ring_indicator_one_n_i, ring_indicator_two_n_i});
    endsequence
    sequence s_ring;
        $changed(ring_indicator_one_n_i) || $changed(ring_indicator_two_n_i);
    endsequence
    a_rsvd_zero: assert property (req_i.rd && req_i.addr == 8'h23
        |=> !rdata_o[4]) else $error("reserved bit set");
    a_susp_write: assert property (s_calm[*3] ##0 s_wr(8'h23)
        |=> {suspend_o, alt_id_en_o} == $past({req_i.wdata[0],
        req_i.wdata[5]})) else $error("suspend write lost");
    a_wake_ends: assert property (s_ring
        |-> ##[1:4] !suspend_o) else $error("no wake");
    a_seg_write: assert property (s_wr(8'h24)
        |=> flash_seg_en_o == $past(req_i.wdata[7:4])) else $error("seg");
    a_flwr_write: assert property (s_wr(8'h24)
        |=> flash_wr_en_o == $past(req_i.wdata[2])) else $error("flwr");
    a_sel1_write: assert property (s_wr(8'h25)
        |=> gpio_sel_one_o == $past(req_i.wdata)) else $error("sel1");
    a_sel2_guard: assert property (s_wr(8'h26) ##0
        logical_device_select_o != 8'h05 |=> $stable(gpio_sel_two_o))
        else $error("sel2 written");
    a_sel2_write: assert property (s_wr(8'h26) ##0
        logical_device_select_o == 8'h05 |=> gpio_sel_two_o ==
        $past(req_i.wdata)) else $error("sel2 lost");
endmodule : gpsc_chk
bind gpsc_top gpsc_chk chk_u (.*);
`default_nettype wire

// File: bench/test_gpsc_top.sv
// testbench: register accesses and pin checks of gpsc_top
// assumes the design files and checker are compiled first
`default_nettype none
module test_gpsc_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_n_i, r1_n, r2_n, susp, alt, fwr, f18, f19, ck;
    gpsc_pkg::gpsc_req_t rq;
    logic [7:0] rdat, ldsel, sel1, sel2, sel3;
    logic [4:0] strap;
    logic [3:0] seg;
    logic [1:0] scr;
    logic [7:0] ra [6] = '{8'h07, 8'h23, 8'h25, 8'h26, 8'h27, 8'h30};
    logic [7:0] fv [3] = '{8'hff, 8'h5a, 8'h00};
    int err_total, n_checks;
    gpsc_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(rq),
        .rdata_o(rdat), .strap_i(strap), .ring_indicator_one_n_i(r1_n),
        .ring_indicator_two_n_i(r2_n), .suspend_o(susp), .alt_id_en_o(alt),
        .scramble_presence_in_sel_o(scr), .flash_seg_en_o(seg),
        .flash_wr_en_o(fwr), .flash_addr_bit18_en_o(f18),
        .flash_addr_bit19_en_o(f19), .input_clock_sel_o(ck),
        .logical_device_select_o(ldsel), .gpio_sel_one_o(sel1),
        .gpio_sel_two_o(sel2), .gpio_sel_three_o(sel3));
    task check(input string nm, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task wr(input logic [7:0] a, d);
        @(posedge clk_i) rq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i) rq <= '0;
    endtask : wr
    task rd(input logic [7:0] a, e);
        @(posedge clk_i) rq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i) rq <= '0;
        #1 check("rdata", rdat, e);
    endtask : rd
    task summarize;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        #50us;
        err_total++;
        summarize();
    end
    initial begin
        {rst_n_i, rq, r1_n, r2_n, strap} = {1'b0, 18'h0, 2'h3, 5'h16};
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(8'h24, 8'hb0);
        foreach (ra[i]) rd(ra[i], 8'h00);
        wr(8'h23, 8'hff);
        #1 check("susp", {4'h0, susp, alt, scr}, 8'h0f);
        rd(8'h23, 8'hef);
        @(posedge clk_i) r1_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(8'h23, 8'hee);
        wr(8'h23, 8'h01);
        @(posedge clk_i) r2_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(8'h23, 8'h00);
        foreach (fv[i]) begin
            wr(8'h24, fv[i]);
            #1 check("clkfl", {seg, f18, fwr, f19, ck}, fv[i]);
            rd(8'h24, fv[i]);
        end
        wr(8'h25, 8'ha5);
        wr(8'h27, 8'h5a);
        wr(8'h26, 8'h3c);
        wr(8'h30, 8'hff);
        #1 check("sel1", sel1, 8'ha5);
        check("sel3", sel3, 8'h5a);
        rd(8'h26, 8'h00);
        rd(8'h30, 8'h00);
        wr(8'h07, 8'h05);
        #1 check("ldsel", ldsel, 8'h05);
        wr(8'h26, 8'h3c);
        #1 check("sel2", sel2, 8'h3c);
        rd(8'h07, 8'h05);
        summarize();
    end
endmodule : test_gpsc_top
`default_nettype wire

// File: rtl/gpsc_pkg.sv
// package: offsets, fields, reset values and carriers of the global
// pin-mux / suspend configuration block.
// assumes a plain register port with index-wide address and byte data.
// Function
// - suspend control resets zero; bit5 alternate id
// - bit0 set enters software suspend state
// - any ring indicator edge ends suspend
// - bit7 enables low-memory flash segment
// - bit6 enables top-of-memory flash segment
// - bits 5,4 enable further high segments
// - bit3 drives flash addr bit18 on pin
// - bit2 clear blocks flash write cycles
// - bit1 drives flash addr bit19 on pin
// - bits 7-3 from straps, 2-0 zero
// - set one selects flash data or gpio
// - set two selects flash address or gpio
// - set two written only when device 05h
// - set three selects flash address or gpio
// - logical device select register steers only set two writes
`default_nettype none
package gpsc_pkg;
    localparam logic [7:0] ADDR_LDSEL = 8'h07;
    localparam logic [7:0] ADDR_SUSP = 8'h23;
    localparam logic [7:0] ADDR_CLKFL = 8'h24;
    localparam logic [7:0] ADDR_SEL1 = 8'h25;
    localparam logic [7:0] ADDR_SEL2 = 8'h26;
    localparam logic [7:0] ADDR_SEL3 = 8'h27;
    localparam logic [7:0] RST_LDSEL = 8'h00;
    localparam logic [7:0] RST_SUSP = 8'h00;
    localparam logic [7:0] RST_SEL = 8'h00;
    localparam logic [2:0] RST_CLKFL_LOW = 3'h0;
    localparam logic [7:0] LD_GPIO = 8'h05;
    localparam logic [7:0] SUSP_WMASK = 8'hef;
    localparam int SUSP_EN_BIT = 0;
    localparam int ALT_ID_BIT = 5;
    localparam int SEG4_BIT = 7;
    localparam int SEG3_BIT = 6;
    localparam int SEG2_BIT = 5;
    localparam int SEG1_BIT = 4;
    localparam int FL4M_BIT = 3;
    localparam int FLWR_BIT = 2;
    localparam int FL8M_BIT = 1;
    localparam int CLKSEL_BIT = 0;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } gpsc_req_t;

    typedef struct packed {
        logic [7:0] ldsel;
        logic [7:0] susp;
        logic [7:0] clkfl;
        logic [7:0] sel1;
        logic [7:0] sel2;
        logic [7:0] sel3;
        logic [7:0] rdata;
        logic strap_done;
        logic [1:0] ri_prev;
        logic ri_valid;
    } gpsc_state_t;
endpackage : gpsc_pkg
`default_nettype wire

// File: rtl/gpsc_top.sv
// module: global configuration registers, software suspend with ring
// wake-up, flash segment enables and per-pin function selects.
// assumes straps stable around reset release; ring inputs asynchronous.
`default_nettype none
module gpsc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port
    input wire gpsc_pkg::gpsc_req_t req_i,
    output logic [7:0] rdata_o,
    // straps and ring inputs
    input wire logic [4:0] strap_i,
    input wire logic ring_indicator_one_n_i,
    input wire logic ring_indicator_two_n_i,
    // control outputs
    output logic suspend_o,
    output logic alt_id_en_o,
    output logic [1:0] scramble_presence_in_sel_o,
    output logic [3:0] flash_seg_en_o,
    output logic flash_wr_en_o,
    output logic flash_addr_bit18_en_o,
    output logic flash_addr_bit19_en_o,
    output logic input_clock_sel_o,
    output logic [7:0] logical_device_select_o,
    output logic [7:0] gpio_sel_one_o,
    output logic [7:0] gpio_sel_two_o,
    output logic [7:0] gpio_sel_three_o
);
    gpsc_pkg::gpsc_state_t st;
    gpsc_pkg::gpsc_state_t next_st;
    logic [1:0] ri_meta;
    logic [1:0] ri_sync;
    logic ri_edge;

    // two-stage synchroniser for ring inputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ri_meta <= 2'h3;
            ri_sync <= 2'h3;
        end else begin
            ri_meta <= {ring_indicator_two_n_i, ring_indicator_one_n_i};
            ri_sync <= ri_meta;
        end
    end

    // either polarity on either input is a wake event
    assign ri_edge = st.ri_valid && (ri_sync != st.ri_prev);

    always_comb begin
        next_st = st;
        next_st.ri_prev = ri_sync;
        next_st.ri_valid = 1'b1;
        next_st.rdata = 8'h00;
        // straps captured once after reset release
        if (!st.strap_done) begin
            next_st.clkfl = {strap_i, st.clkfl[2:0]};
            next_st.strap_done = 1'b1;
        end
        if (req_i.wr) begin
            if (req_i.addr == gpsc_pkg::ADDR_LDSEL) begin
                next_st.ldsel = req_i.wdata;
            end else if (req_i.addr == gpsc_pkg::ADDR_SUSP) begin
                next_st.susp = req_i.wdata & gpsc_pkg::SUSP_WMASK;
            end else if (req_i.addr == gpsc_pkg::ADDR_CLKFL) begin
                next_st.clkfl = req_i.wdata;
            end else if (req_i.addr == gpsc_pkg::ADDR_SEL1) begin
                next_st.sel1 = req_i.wdata;
            end else if (req_i.addr == gpsc_pkg::ADDR_SEL2) begin
                if (st.ldsel == gpsc_pkg::LD_GPIO) begin
                    next_st.sel2 = req_i.wdata;
                end
            end else if (req_i.addr == gpsc_pkg::ADDR_SEL3) begin
                next_st.sel3 = req_i.wdata;
            end
        end
        // wake event wins over a simultaneous write setting suspend
        if (ri_edge) begin
            next_st.susp[gpsc_pkg::SUSP_EN_BIT] = 1'b0;
        end
        if (req_i.rd) begin
            if (req_i.addr == gpsc_pkg::ADDR_LDSEL) begin
                next_st.rdata = st.ldsel;
            end else if (req_i.addr == gpsc_pkg::ADDR_SUSP) begin
                next_st.rdata = st.susp;
            end else if (req_i.addr == gpsc_pkg::ADDR_CLKFL) begin
                next_st.rdata = st.clkfl;
            end else if (req_i.addr == gpsc_pkg::ADDR_SEL1) begin
                next_st.rdata = st.sel1;
            end else if (req_i.addr == gpsc_pkg::ADDR_SEL2) begin
                next_st.rdata = st.sel2;
            end else if (req_i.addr == gpsc_pkg::ADDR_SEL3) begin
                next_st.rdata = st.sel3;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st.ldsel <= gpsc_pkg::RST_LDSEL;
            st.susp <= gpsc_pkg::RST_SUSP;
            st.clkfl <= {5'h00, gpsc_pkg::RST_CLKFL_LOW};
            st.sel1 <= gpsc_pkg::RST_SEL;
            st.sel2 <= gpsc_pkg::RST_SEL;
            st.sel3 <= gpsc_pkg::RST_SEL;
            st.rdata <= 8'h00;
            st.strap_done <= 1'b0;
            st.ri_prev <= 2'h3;
            st.ri_valid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign suspend_o = st.susp[gpsc_pkg::SUSP_EN_BIT];
    assign alt_id_en_o = st.susp[gpsc_pkg::ALT_ID_BIT];
    assign scramble_presence_in_sel_o = st.susp[7:6];
    assign flash_seg_en_o[3] = st.clkfl[gpsc_pkg::SEG4_BIT];
    assign flash_seg_en_o[2] = st.clkfl[gpsc_pkg::SEG3_BIT];
    assign flash_seg_en_o[1] = st.clkfl[gpsc_pkg::SEG2_BIT];
    assign flash_seg_en_o[0] = st.clkfl[gpsc_pkg::SEG1_BIT];
    assign flash_wr_en_o = st.clkfl[gpsc_pkg::FLWR_BIT];
    assign flash_addr_bit18_en_o = st.clkfl[gpsc_pkg::FL4M_BIT];
    assign flash_addr_bit19_en_o = st.clkfl[gpsc_pkg::FL8M_BIT];
    assign input_clock_sel_o = st.clkfl[gpsc_pkg::CLKSEL_BIT];
    assign logical_device_select_o = st.ldsel;
    assign gpio_sel_one_o = st.sel1;
    assign gpio_sel_two_o = st.sel2;
    assign gpio_sel_three_o = st.sel3;
endmodule : gpsc_top
`default_nettype wire
